// file: core/vdsc_pkg.sv
package vdsc_pkg;

	// Clock and internal time base.
	localparam int unsigned CORE_CLK_HZ     = 25_000_000;
	localparam int unsigned SAMPLE_CLK_HZ   = 5_550_000;
	// Sample tick period in core clocks, rounded down (fastest allowed rate).
	localparam int unsigned SAMPLE_DIV      = CORE_CLK_HZ / SAMPLE_CLK_HZ;
	localparam int unsigned STEP_DIV        = 3;
	localparam int unsigned NORMAL_STABLE   = 3;
	localparam int unsigned OFF_STABLE      = 4;

	// Code width and off codes.
	localparam int unsigned CODE_W          = 8;
	localparam logic [7:0]  OFF_CODE_A      = 8'h_FF;
	localparam logic [7:0]  OFF_CODE_B      = 8'h_FE;
	localparam logic [7:0]  DAC_RESET       = 8'h_00;
	localparam int unsigned PHASES          = 3;

	// Comparator inputs of one phase.
	typedef struct packed {
		logic pwm;
		logic low_gate_below_th;
		logic high_gate_below_th;
		logic switch_node_low;
	} vdsc_phase_in_t;

	// Gate drive pair of one phase.
	typedef struct packed {
		logic high_side_gate;
		logic low_side_gate;
	} vdsc_gate_t;

	typedef enum logic [1:0] {
		VDSC_BOTH_OFF = 2'b00,
		VDSC_HIGH_ON  = 2'b01,
		VDSC_LOW_ON   = 2'b10
	} vdsc_drv_state_t;

endpackage : vdsc_pkg

// file: core/vdsc_gate_seq.sv
`timescale 1ns/10ps
`default_nettype none
module vdsc_gate_seq
	import vdsc_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           reset,
	input  wire logic           run,
	input  wire vdsc_phase_in_t ph_in,
	output vdsc_gate_t          gate
);

	typedef struct packed {
		vdsc_drv_state_t st;
		vdsc_gate_t      g;
	} vdsc_seq_state_t;

	vdsc_seq_state_t state_ff;
	vdsc_seq_state_t nxt_state;

	// Non-overlapping gate sequencer; high gate rises once low is seen off, low once high is off or the switch node is low.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff.st)
			VDSC_BOTH_OFF: begin
				if (ph_in.pwm && ph_in.low_gate_below_th) begin
					nxt_state.st = VDSC_HIGH_ON;
				end else if (!ph_in.pwm &&
				             (ph_in.high_gate_below_th || ph_in.switch_node_low)) begin
					nxt_state.st = VDSC_LOW_ON;
				end
			end
			VDSC_HIGH_ON: begin
				if (!ph_in.pwm) begin
					nxt_state.st = VDSC_BOTH_OFF;
				end
			end
			VDSC_LOW_ON: begin
				if (ph_in.pwm) begin
					nxt_state.st = VDSC_BOTH_OFF;
				end
			end
			default: begin
				nxt_state.st = VDSC_BOTH_OFF;
			end
		endcase
		if (!run) begin
			nxt_state.st = VDSC_BOTH_OFF;
		end
		nxt_state.g.high_side_gate = (nxt_state.st == VDSC_HIGH_ON);
		nxt_state.g.low_side_gate  = (nxt_state.st == VDSC_LOW_ON);
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign gate = state_ff.g;

endmodule : vdsc_gate_seq
`default_nettype wire

// file: core/vdsc_top.sv
// Summary of operation
// - Sample the identification code against the DAC code on each 6.25MHz tick (SAMPLE_DIV of 4 core clocks).
// - Accept a new normal code after three identical consecutive samples.
// - Step the DAC code one LSB per 2.08MHz strobe (every 12 core clocks) toward target.
// - Keep stepping until DAC equals the accepted code, then hold.
// - Recognise an off code after four identical consecutive samples.
// - On off code, stop regulation and drive all gates off.
// - Off state stays latched until enable is dropped and raised again.
// - High-side gate waits until low-side gate has fallen below threshold.
// - Low-side gate waits for high gate below threshold or switch node low.
// - While disabled, hold every high and low gate drive low.
`timescale 1ns/10ps
`default_nettype none
module vdsc_top
	import vdsc_pkg::*;
#(
	parameter int unsigned N_PHASE = PHASES
)(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  enable,
	input  wire logic [CODE_W-1:0]     voltage_id_code,
	input  wire vdsc_phase_in_t [N_PHASE-1:0] phase_in,
	output logic [CODE_W-1:0]          dac_code,
	output logic                       regulating,
	output logic                       off_latched,
	output vdsc_gate_t [N_PHASE-1:0]   gate_out
);

	// Off code decode, used in the filter and the latch.
	function automatic logic vdsc_is_off(input logic [CODE_W-1:0] c);
		return (c == OFF_CODE_A) || (c == OFF_CODE_B);
	endfunction : vdsc_is_off

	// Timing overview, in core clocks.
	// The identification pins and the enable pin pass two flip-flops before the filter sees
	// them, so a pin change reaches the compare two clocks after it is launched.
	// The sample tick repeats every SAMPLE_DIV clocks. Rounding the divider down makes the
	// sampling slightly faster than nominal, which shortens the glitch window a little but
	// never lets a code through on fewer identical samples than the rules ask for.
	// The step strobe is every third tick, so the DAC moves at most one code per
	// SAMPLE_DIV * STEP_DIV clocks, whatever the size of the requested change.
	// A sample equal to the present DAC code clears the filter and pins the target to the
	// DAC, so a code that returns to where the DAC already stands stops any slew, except that a step on that same tick still moves the DAC one code.
	// Off codes use the same candidate and counter as normal codes but need one more
	// identical sample. They never become a target, so the DAC does not move toward them.
	// The off latch only sets while the synchronised enable is high, and a low enable
	// clears it on every clock, so dropping enable is the only way out of the off state.
	// The comparator inputs of every phase are synchronised here as well, so the gate
	// sequencers see only settled levels; the extra latency only lengthens the dead time.

	typedef struct packed {
		vdsc_phase_in_t [N_PHASE-1:0] ph_s1;
		vdsc_phase_in_t [N_PHASE-1:0] ph_s2;
		logic [CODE_W-1:0] id_s1;
		logic [CODE_W-1:0] id_s2;
		logic              en_s1;
		logic              en_s2;
		logic              en_prev;
		logic [2:0]        tick_cnt;
		logic [1:0]        step_cnt;
		logic [CODE_W-1:0] cand;
		logic [2:0]        same_cnt;
		logic [CODE_W-1:0] target;
		logic [CODE_W-1:0] dac;
		logic              off;
	} vdsc_top_state_t;

	vdsc_top_state_t state_ff;
	vdsc_top_state_t nxt_state;
	logic            tick;
	logic            step;
	logic            run;

	assign tick = (state_ff.tick_cnt == 3'(SAMPLE_DIV - 1));
	assign step = tick && (state_ff.step_cnt == 2'(STEP_DIV - 1));
	assign run  = state_ff.en_s2 && !state_ff.off;

	// Synchronise pins, filter the code, step the DAC and keep the off latch.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.id_s1   = voltage_id_code;
		nxt_state.id_s2   = state_ff.id_s1;
		nxt_state.en_s1   = enable;
		nxt_state.en_s2   = state_ff.en_s1;
		nxt_state.en_prev = state_ff.en_s2;
		// Two-stage synchroniser for the comparator inputs of all phases.
		nxt_state.ph_s1   = phase_in;
		nxt_state.ph_s2   = state_ff.ph_s1;
		nxt_state.tick_cnt = tick ? 3'd0 : state_ff.tick_cnt + 3'd1;
		if (tick) begin
			nxt_state.step_cnt = (state_ff.step_cnt == 2'(STEP_DIV - 1)) ? 2'd0
			                     : state_ff.step_cnt + 2'd1;
			if (state_ff.id_s2 == state_ff.dac && !vdsc_is_off(state_ff.id_s2)) begin
				nxt_state.same_cnt = 3'd0;
				nxt_state.target   = state_ff.dac;
			end else if (state_ff.id_s2 != state_ff.cand) begin
				nxt_state.cand     = state_ff.id_s2;
				nxt_state.same_cnt = 3'd1;
			end else if (state_ff.same_cnt != 3'd7) begin
				nxt_state.same_cnt = state_ff.same_cnt + 3'd1;
			end
			if (vdsc_is_off(state_ff.id_s2)) begin
				if (state_ff.id_s2 == state_ff.cand &&
				    state_ff.same_cnt >= 3'(OFF_STABLE - 1) && state_ff.en_s2) begin
					nxt_state.off = 1'b1;
				end
			end else if (state_ff.id_s2 == state_ff.cand &&
			             state_ff.same_cnt >= 3'(NORMAL_STABLE - 1)) begin
				// The count saturates, so a long-held code is still accepted.
				nxt_state.target = state_ff.cand;
			end
		end
		if (step && run) begin
			if (state_ff.target > state_ff.dac) begin
				nxt_state.dac = state_ff.dac + 8'd1;
			end else if (state_ff.target < state_ff.dac) begin
				nxt_state.dac = state_ff.dac - 8'd1;
			end
		end
		if (!state_ff.en_s2) begin
			nxt_state.off = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// One gate sequencer per phase, all stopped by the off latch.
	genvar gi;
	generate
		for (gi = 0; gi < N_PHASE; gi++) begin : g_phase
			vdsc_gate_seq u_seq (
				.core_clk (core_clk),
				.reset    (reset),
				.run      (run),
				.ph_in    (state_ff.ph_s2[gi]),
				.gate     (gate_out[gi])
			);
		end
	endgenerate

	assign dac_code    = state_ff.dac;
	assign regulating  = run;
	assign off_latched = state_ff.off;

endmodule : vdsc_top
`default_nettype wire

// file: dv/vdsc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module vdsc_cpu_model
	import vdsc_pkg::*;
(
	input wire logic [CODE_W-1:0]	want_code,
	input wire logic	core_clk,
	input wire logic [PHASES-1:0]	pwm,
	input wire vdsc_gate_t [PHASES-1:0]	gate,
	output logic [CODE_W-1:0]	voltage_id_code = '0,
	output vdsc_phase_in_t [PHASES-1:0]	phase_in = '0
);
	// Code pins move off the sampling edge; comparators report gates that are off.
	always @(negedge core_clk) begin
		voltage_id_code <= want_code;
		for (int i = 0; i < PHASES; i++) begin
			phase_in[i] <= {pwm[i], !gate[i].low_side_gate, {2{!gate[i].high_side_gate}}};
		end
	end
endmodule : vdsc_cpu_model
`default_nettype wire

// file: dv/vdsc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module vdsc_top_sva
	import vdsc_pkg::*;
#(parameter int unsigned N_PHASE = PHASES)(
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	enable,
	input wire logic [CODE_W-1:0]	dac_code,
	input wire logic	regulating,
	input wire logic	off_latched,
	input wire vdsc_gate_t [N_PHASE-1:0]	gate_out
);
	// All checks share the core clock and its reset.
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	hi_gap_a: assert property (
		$rose(gate_out[0].high_side_gate) |-> !$past(gate_out[0].low_side_gate))
		else $error("high gate overlap");
	lo_gap_a: assert property (
		$rose(gate_out[0].low_side_gate) |-> !$past(gate_out[0].high_side_gate))
		else $error("low gate overlap");
	step_one_a: assert property (
		$changed(dac_code) |-> dac_code - $past(dac_code) inside {8'h_01, 8'h_FF})
		else $error("step size");
	step_gap_a: assert property (
		$changed(dac_code) |=> $stable(dac_code)[*8])
		else $error("step rate");
	off_gate_a: assert property (
		off_latched[*4] |-> gate_out == '0)
		else $error("gates on when off");
	off_run_a: assert property (
		off_latched |-> !regulating)
		else $error("running when off");
	off_hold_a: assert property (
		enable[*4] ##0 off_latched |=> off_latched)
		else $error("off cleared");
	dis_run_a: assert property (
		(!enable)[*6] |-> !regulating && gate_out == '0)
		else $error("active when disabled");
endmodule : vdsc_top_sva
bind vdsc_top vdsc_top_sva #(.N_PHASE(N_PHASE)) u_sva (.core_clk(core_clk), .reset(reset),
	.enable(enable), .dac_code(dac_code), .regulating(regulating),
	.off_latched(off_latched), .gate_out(gate_out));
`default_nettype wire

// file: dv/vid_dac_slew_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vid_dac_slew_controller_tb;
	import vdsc_pkg::*;
	logic	core_clk = 1'b1;
	logic	reset = 1'b1;
	logic	enable = 1'b1;
	logic [CODE_W-1:0]	want = '0;
	logic [CODE_W-1:0]	vid;
	logic [CODE_W-1:0]	dac_code;
	logic [PHASES-1:0]	pwm = '0;
	logic	regulating;
	logic	off_latched;
	vdsc_phase_in_t [PHASES-1:0]	phase_in;
	vdsc_gate_t [PHASES-1:0]	gate_out;
	int	num_errors = 0;
	int	comparisons = 0;
	// Clock and random pulse-width demand.
	always #20 core_clk = ~core_clk;
	always @(negedge core_clk) begin
		pwm <= PHASES'($urandom);
	end
	vdsc_top dut (.core_clk(core_clk), .reset(reset), .enable(enable), .voltage_id_code(vid),
		.phase_in(phase_in), .dac_code(dac_code), .regulating(regulating),
		.off_latched(off_latched), .gate_out(gate_out));
	vdsc_cpu_model u_cpu (.want_code(want), .core_clk(core_clk), .pwm(pwm), .gate(gate_out),
		.voltage_id_code(vid), .phase_in(phase_in));
	task automatic check(string what, logic [CODE_W-1:0] exp, logic [CODE_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic ticks(int n);
		repeat (n) @(negedge core_clk);
	endtask : ticks
	// Settling time: sync, filter, then one step per twelve clocks.
	function automatic int settle(logic [CODE_W-1:0] a, logic [CODE_W-1:0] b);
		return 40 + 12 * ((a > b) ? a - b : b - a);
	endfunction : settle
	task automatic complete_run;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// Watchdog well beyond the longest expected run.
	initial begin
		#3_000_000;
		num_errors++;
		complete_run();
	end
	// Main sequence: slews, a glitch, a short off code, then both off codes.
	initial begin
		logic [CODE_W-1:0] tgt;
		logic [CODE_W-1:0] offs [2] = '{OFF_CODE_A, OFF_CODE_B};
		void'($urandom(32'heac2));
		ticks(12);
		reset = 1'b0;
		check("dac reset", DAC_RESET, dac_code);
		for (int i = 0; i < 6; i++) begin
			tgt = (i == 0) ? 8'h_FD : 8'($urandom_range(253));
			want = tgt;
			ticks(settle(dac_code, tgt));
			check("dac slew", tgt, dac_code);
			check("no off", 8'h_00, {7'h_00, off_latched});
		end
		want = tgt ^ 8'h_10;
		ticks(6);
		want = tgt;
		ticks(60);
		check("glitch", tgt, dac_code);
		want = OFF_CODE_A;
		ticks(11);
		want = tgt;
		ticks(20);
		check("short off", 8'h_00, {7'h_00, off_latched});
		foreach (offs[k]) begin
			want = offs[k];
			ticks(24);
			check("off", 8'h_01, {7'h_00, off_latched});
			check("off gates", 8'h_00, 8'(gate_out));
			want = 8'h_20;
			ticks(80);
			check("latch", 8'h_01, {7'h_00, off_latched});
			enable = 1'b0;
			ticks(8);
			check("disabled", 8'h_00, {7'h_00, regulating});
			enable = 1'b1;
			ticks(8);
			check("cleared", 8'h_01, {7'h_00, regulating});
		end
		complete_run();
	end
endmodule : vid_dac_slew_controller_tb
`default_nettype wire
